// ### apcl_pkg.sv
// Constants shared by the audio port clocking, companding and loopback block.
// Assumes a 25 MHz system clock and an APB register bus with 32-bit data.
package apcl_pkg;

	// Printed register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL0 = 6'h18;
	localparam logic [5:0] IDX_CTRL1 = 6'h19;
	localparam logic [5:0] IDX_BCDIV = 6'h1a;
	localparam logic [5:0] IDX_RATE = 6'h1b;
	localparam logic [5:0] IDX_PORT = 6'h1c;
	localparam logic [7:0] ADDR_CTRL0 = {IDX_CTRL0, 2'b00};
	localparam logic [7:0] ADDR_CTRL1 = {IDX_CTRL1, 2'b00};
	localparam logic [7:0] ADDR_BCDIV = {IDX_BCDIV, 2'b00};
	localparam logic [7:0] ADDR_RATE = {IDX_RATE, 2'b00};
	localparam logic [7:0] ADDR_PORT = {IDX_PORT, 2'b00};

	// Writable masks and reset values
	localparam logic [15:0] CTRL0_MASK = 16'h19ff;
	localparam logic [15:0] CTRL0_RESET = 16'h0050;
	localparam logic [15:0] CTRL1_MASK = 16'h3edf;
	localparam logic [15:0] CTRL1_RESET = 16'h0002;
	localparam logic [15:0] BCDIV_MASK = 16'h001f;
	localparam logic [15:0] BCDIV_RESET = 16'h0008;
	localparam logic [15:0] RATE_MASK = 16'h07ff;
	localparam logic [15:0] RATE_RESET = 16'h0022;
	localparam logic [15:0] PORT_MASK = 16'h00f7;
	localparam logic [15:0] PORT_RESET = 16'h0010;

	// Field positions
	localparam int CTRL0_LOOPBACK = 8;
	localparam int CTRL0_TX_COMP = 3;
	localparam int CTRL0_TX_TYPE = 2;
	localparam int CTRL0_RX_COMP = 1;
	localparam int CTRL0_RX_TYPE = 0;
	localparam int CTRL1_FRAME_DIR = 9;
	localparam int CTRL1_BIT_DIR = 6;
	localparam int CTRL1_DSP_B = 4;
	localparam int CTRL1_WL_LO = 2;
	localparam int PORT_ADC_EN = 0;
	localparam int PORT_DAC_EN = 1;
	localparam int PORT_SIDETONE = 2;
	localparam int PORT_FN_LO = 4;
	localparam int PORT_ST_BIT = 8;
	localparam int PORT_ST_FRAME = 9;
	localparam int PORT_ST_EIGHT = 10;

	// Pin synchroniser lanes
	localparam int SYN_MCLK = 0;
	localparam int SYN_BCLK = 1;
	localparam int SYN_FRAME = 2;
	localparam int SYN_SDATA = 3;

	localparam logic [3:0] PIN_FN_BITCLK = 4'h1;
	localparam logic [10:0] FRAME_RATE_MIN = 11'h008;
	localparam logic [10:0] BIT_RATIO_DEFAULT = 11'h008;

	// Bit clock ratio per divider code; zero marks a reserved code
	localparam logic [5:0] BIT_RATIO [32] = '{
		6'h01, 6'h00, 6'h02, 6'h03, 6'h04, 6'h05, 6'h00, 6'h06,
		6'h08, 6'h0a, 6'h00, 6'h0c, 6'h10, 6'h14, 6'h16, 6'h18,
		6'h00, 6'h1e, 6'h20, 6'h2c, 6'h30, 6'h00, 6'h00, 6'h00,
		6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};

	typedef enum logic [2:0] {
		SER_IDLE = 3'b001,
		SER_ALIGN = 3'b010,
		SER_SHIFT = 3'b100
	} apcl_ser_t;

endpackage

// ### apcl_clkdiv.sv
// Integer clock divider producing a level that advances on each tick.
// Assumes ratio is at least 2; the caller clamps it.
`timescale 1ns/1ns
`default_nettype none
module apcl_clkdiv (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic run,
	input wire logic tick,
	input wire logic [10:0] ratio,
	output logic level
);
	typedef struct packed {
		logic [10:0] cnt;
		logic lvl;
	} apcl_div_t;

	apcl_div_t r;
	apcl_div_t n;
	logic [10:0] half;

	always_comb begin
		n = r;
		half = ratio >> 1;
		if (!run) begin
			n.cnt = 11'h000;
			n.lvl = 1'b0;
		end else if (tick) begin
			if (r.cnt >= ratio - 11'h001) begin
				n.cnt = 11'h000;
				n.lvl = 1'b1;
			end else begin
				n.cnt = r.cnt + 11'h001;
				// Even ratios give equal high and low halves
				if (r.cnt + 11'h001 == half) begin
					n.lvl = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign level = r.lvl;
endmodule // apcl_clkdiv
`default_nettype wire

// ### apcl_compand.sv
// Combinational 8-bit mu-law and A-law compressor and expander.
// Assumes linear samples are 24-bit two's complement, left aligned.
`timescale 1ns/1ns
`default_nettype none
module apcl_compand (
	input wire logic [23:0] txLinear,
	input wire logic txCompEn,
	input wire logic txAlaw,
	output logic [7:0] txByte,
	input wire logic [7:0] rxByte,
	input wire logic rxCompEn,
	input wire logic rxAlaw,
	output logic [23:0] rxLinear
);
	function automatic logic [7:0] muEnc(input logic [13:0] x);
		logic neg;
		logic [12:0] mag;
		logic [13:0] b;
		logic [2:0] e;
		logic [3:0] m;
		neg = x[13];
		mag = neg ? ~x[12:0] : x[12:0];
		if (mag > 13'h1fde) begin
			mag = 13'h1fde;
		end
		b = {1'b0, mag} + 14'h0021;
		e = 3'h0;
		for (int i = 5; i < 13; i++) begin
			if (b[i]) begin
				e = 3'(i - 5);
			end
		end
		m = 4'(b >> ({1'b0, e} + 4'h1));
		return ~{neg, e, m};
	endfunction

	function automatic logic [13:0] muDec(input logic [7:0] c);
		logic [7:0] raw;
		logic [13:0] t;
		raw = ~c;
		t = ({9'h000, raw[3:0], 1'b0} + 14'h0021) << raw[6:4];
		t = t - 14'h0021;
		return raw[7] ? ~t : t;
	endfunction

	function automatic logic [7:0] aEnc(input logic [12:0] x);
		logic neg;
		logic [11:0] mag;
		logic [2:0] e;
		logic [3:0] m;
		neg = x[12];
		mag = neg ? ~x[11:0] : x[11:0];
		e = 3'h0;
		for (int i = 5; i < 12; i++) begin
			if (mag[i]) begin
				e = 3'(i - 4);
			end
		end
		m = (e == 3'h0) ? 4'(mag >> 1) : 4'(mag >> e);
		return {~neg, e, m} ^ 8'h55;
	endfunction

	function automatic logic [12:0] aDec(input logic [7:0] c);
		logic [7:0] raw;
		logic [11:0] t;
		raw = c ^ 8'h55;
		if (raw[6:4] == 3'h0) begin
			t = {7'h00, raw[3:0], 1'b1};
		end else begin
			t = ({7'h00, raw[3:0], 1'b1} + 12'h020) << (raw[6:4] - 3'h1);
		end
		return raw[7] ? {1'b0, t} : ~{1'b0, t};
	endfunction

	// Sign bit 7, exponent 6:4, mantissa 3:0; laws work on top bits
	always_comb begin
		if (!txCompEn) begin
			txByte = txLinear[23:16];
		end else if (txAlaw) begin
			txByte = aEnc(txLinear[23:11]);
		end else begin
			txByte = muEnc(txLinear[23:10]);
		end
	end

	always_comb begin
		if (!rxCompEn) begin
			rxLinear = {rxByte, 16'h0000};
		end else if (rxAlaw) begin
			rxLinear = {aDec(rxByte), 11'h000};
		end else begin
			rxLinear = {muDec(rxByte), 10'h000};
		end
	end
endmodule // apcl_compand
`default_nettype wire

// ### apcl_top.sv
// Audio serial port clock direction and rate logic, companding and loopback.
// Assumes a 25 MHz system clock, an APB master, and a DSP-style serial frame.
//
// Contract
// - Bit clock and frame clock direction are chosen independently.
// - Master clocks run only while an ADC or DAC channel is enabled.
// - In slave mode clock drivers are off; the partner drives both clocks.
// - Bit clock input with pin function not one uses the master clock input.
// - Output bit clock comes from the system clock divider; input ignores it.
// - Five-bit divider code maps to fixed ratios; reserved codes; reset divide by 8.
// - Output frame clock is derived from the bit clock, internal or external.
// - Frame clock equals bit clock over the 11-bit rate, 8 to 2047, reset 34.
// - Equal high and low frame clock halves needed only for even rates.
// - Frame rate field is ignored when the frame clock is an input.
// - Separate compand enable and type for transmit and receive; 0 mu, 1 A.
// - Piecewise mu-law and A-law map 13 or 12 bit magnitudes to bytes.
// - Invert all code bits for mu-law, even bits for A-law, both ways.
// - The companded byte sits in the top eight bits of the serial word.
// - Byte holds sign in bit 7, exponent 6 to 4, mantissa 3 to 0.
// - Any compand enable forces 8-bit samples, frames as short as 8 bits.
// - DSP mode B carries back-to-back 8-bit words every 8 bit clocks.
// - Type bits without enables give plain linear 8-bit samples.
// - Loopback routes ADC data into the DAC path and ignores receive data.
// - Sidetone keeps being added to DAC data during loopback.
// - Mode B MSB valid on first bit rise after frame rise, mode A second.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module apcl_top (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic masterClockIn,
	input wire logic bitClockIn,
	output logic bitClockOut,
	output logic bitClockOe_n,
	input wire logic frameClockIn,
	output logic frameClockOut,
	output logic frameClockOe_n,
	input wire logic serialReceiveData,
	output logic serialTransmitData,
	input wire logic [23:0] adcSample,
	input wire logic adcValid,
	input wire logic [23:0] sidetoneSample,
	output logic [23:0] dacSample,
	output logic dacValid
);
	typedef struct packed {
		logic [15:0] ctrl0;
		logic [15:0] ctrl1;
		logic [15:0] bcdiv;
		logic [15:0] rate;
		logic [15:0] port;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [3:0] syncA;
		logic [3:0] syncB;
		logic bitPrev;
		logic framePrev;
		apcl_pkg::apcl_ser_t ser;
		logic [1:0] align;
		logic [5:0] bitCnt;
		logic [31:0] txShift;
		logic [31:0] rxShift;
		logic sdout;
		logic [23:0] adcHeld;
		logic [23:0] dac;
		logic dacValid;
		logic bitOe_n;
		logic frameOe_n;
	} apcl_state_t;

	apcl_state_t r;
	apcl_state_t n;

	logic dirBit;
	logic dirFrame;
	logic modeB;
	logic chanOn;
	logic eightBit;
	logic loopback;
	logic [5:0] wordLen;
	logic [5:0] codeRatio;
	logic [10:0] bitRatio;
	logic [10:0] frameRatio;
	logic bitRun;
	logic frameRun;
	logic bitGenLvl;
	logic frameGenLvl;
	logic bitLvl;
	logic frameLvl;
	logic bitRise;
	logic bitFall;
	logic frameRise;
	logic [31:0] rxNew;
	logic [31:0] rxAligned;
	logic [7:0] txByte;
	logic [23:0] rxExpanded;
	logic [23:0] rxLinear;
	logic rxDone;
	logic setup;
	logic access;
	logic [15:0] rdVal;
	logic miss;

	function automatic logic [23:0] satAdd(input logic [23:0] a, input logic [23:0] b);
		logic [24:0] s;
		s = {a[23], a} + {b[23], b};
		if (s[24] != s[23]) begin
			return s[24] ? 24'h80_0000 : 24'h7f_ffff;
		end
		return s[23:0];
	endfunction

	apcl_clkdiv u_bitDiv (
		.clock(clock),
		.reset_n(reset_n),
		.run(bitRun),
		.tick(1'b1),
		.ratio(bitRatio),
		.level(bitGenLvl)
	);

	apcl_clkdiv u_frameDiv (
		.clock(clock),
		.reset_n(reset_n),
		.run(frameRun),
		.tick(bitRise),
		.ratio(frameRatio),
		.level(frameGenLvl)
	);

	apcl_compand u_compand (
		.txLinear(r.adcHeld),
		.txCompEn(r.ctrl0[apcl_pkg::CTRL0_TX_COMP]),
		.txAlaw(r.ctrl0[apcl_pkg::CTRL0_TX_TYPE]),
		.txByte(txByte),
		.rxByte(rxAligned[31:24]),
		.rxCompEn(r.ctrl0[apcl_pkg::CTRL0_RX_COMP]),
		.rxAlaw(r.ctrl0[apcl_pkg::CTRL0_RX_TYPE]),
		.rxLinear(rxExpanded)
	);

	// Clock configuration
	always_comb begin
		dirBit = r.ctrl1[apcl_pkg::CTRL1_BIT_DIR];
		dirFrame = r.ctrl1[apcl_pkg::CTRL1_FRAME_DIR];
		modeB = r.ctrl1[apcl_pkg::CTRL1_DSP_B];
		loopback = r.ctrl0[apcl_pkg::CTRL0_LOOPBACK];
		chanOn = r.port[apcl_pkg::PORT_ADC_EN] | r.port[apcl_pkg::PORT_DAC_EN];
		eightBit = r.ctrl0[apcl_pkg::CTRL0_TX_COMP] | r.ctrl0[apcl_pkg::CTRL0_RX_COMP]
			| r.ctrl0[apcl_pkg::CTRL0_TX_TYPE] | r.ctrl0[apcl_pkg::CTRL0_RX_TYPE];
		if (eightBit) begin
			wordLen = 6'h08;
		end else begin
			case (r.ctrl1[apcl_pkg::CTRL1_WL_LO +: 2])
				2'b00: wordLen = 6'h10;
				2'b01: wordLen = 6'h14;
				2'b10: wordLen = 6'h18;
				default: wordLen = 6'h20;
			endcase
		end
		codeRatio = apcl_pkg::BIT_RATIO[r.bcdiv[4:0]];
		// Reserved codes fall back to the reset ratio; divide by one runs at half rate
		if (codeRatio == 6'h00) begin
			bitRatio = apcl_pkg::BIT_RATIO_DEFAULT;
		end else if (codeRatio == 6'h01) begin
			bitRatio = 11'h002;
		end else begin
			bitRatio = {5'h00, codeRatio};
		end
		if (r.rate[10:0] < apcl_pkg::FRAME_RATE_MIN) begin
			frameRatio = apcl_pkg::FRAME_RATE_MIN;
		end else begin
			frameRatio = r.rate[10:0];
		end
		bitRun = dirBit & chanOn;
		frameRun = dirFrame & chanOn;
		if (dirBit) begin
			bitLvl = bitGenLvl;
		end else if (r.port[apcl_pkg::PORT_FN_LO +: 4] != apcl_pkg::PIN_FN_BITCLK) begin
			bitLvl = r.syncB[apcl_pkg::SYN_MCLK];
		end else begin
			bitLvl = r.syncB[apcl_pkg::SYN_BCLK];
		end
		frameLvl = dirFrame ? frameGenLvl : r.syncB[apcl_pkg::SYN_FRAME];
		bitRise = bitLvl & ~r.bitPrev;
		bitFall = ~bitLvl & r.bitPrev;
		frameRise = frameLvl & ~r.framePrev;
		rxNew = {r.rxShift[30:0], r.syncB[apcl_pkg::SYN_SDATA]};
		rxAligned = rxNew << (6'h20 - wordLen);
		rxLinear = eightBit ? rxExpanded : rxAligned[31:8];
	end

	// Register decode for the setup phase
	always_comb begin
		rdVal = 16'h0000;
		miss = 1'b0;
		if (paddr == apcl_pkg::ADDR_CTRL0) begin
			rdVal = r.ctrl0;
		end else if (paddr == apcl_pkg::ADDR_CTRL1) begin
			rdVal = r.ctrl1;
		end else if (paddr == apcl_pkg::ADDR_BCDIV) begin
			rdVal = r.bcdiv;
		end else if (paddr == apcl_pkg::ADDR_RATE) begin
			rdVal = r.rate;
		end else if (paddr == apcl_pkg::ADDR_PORT) begin
			rdVal = r.port;
			rdVal[apcl_pkg::PORT_ST_BIT] = bitRun;
			rdVal[apcl_pkg::PORT_ST_FRAME] = frameRun;
			rdVal[apcl_pkg::PORT_ST_EIGHT] = eightBit;
		end else begin
			miss = 1'b1;
		end
	end

	always_comb begin
		n = r;
		setup = psel & ~penable;
		access = psel & penable & r.pready;
		rxDone = 1'b0;

		// Bus slave: one wait-free access phase, answer prepared at setup
		n.pready = setup;
		n.pslverr = setup & miss;
		if (setup) begin
			n.prdata = {16'h0000, rdVal};
		end
		if (access && pwrite && !r.pslverr) begin
			if (paddr == apcl_pkg::ADDR_CTRL0) begin
				n.ctrl0 = pwdata[15:0] & apcl_pkg::CTRL0_MASK;
			end else if (paddr == apcl_pkg::ADDR_CTRL1) begin
				n.ctrl1 = pwdata[15:0] & apcl_pkg::CTRL1_MASK;
			end else if (paddr == apcl_pkg::ADDR_BCDIV) begin
				n.bcdiv = pwdata[15:0] & apcl_pkg::BCDIV_MASK;
			end else if (paddr == apcl_pkg::ADDR_RATE) begin
				n.rate = pwdata[15:0] & apcl_pkg::RATE_MASK;
			end else if (paddr == apcl_pkg::ADDR_PORT) begin
				n.port = pwdata[15:0] & apcl_pkg::PORT_MASK;
			end
		end

		// Pins pass two flops before use
		n.syncA = {serialReceiveData, frameClockIn, bitClockIn, masterClockIn};
		n.syncB = r.syncA;
		n.bitPrev = bitLvl;
		n.framePrev = frameLvl;
		n.bitOe_n = ~dirBit;
		n.frameOe_n = ~dirFrame;

		if (adcValid) begin
			n.adcHeld = adcSample;
		end

		// Serial word engine, DSP-style framing
		case (r.ser)
			apcl_pkg::SER_IDLE: begin
				if (frameRise) begin
					n.ser = apcl_pkg::SER_ALIGN;
					n.align = modeB ? 2'h1 : 2'h2;
				end
			end
			apcl_pkg::SER_ALIGN: begin
				if (bitFall) begin
					if (r.align == 2'h1) begin
						// Eight-bit word carries the byte in its top bits
						n.txShift = eightBit ? {txByte, 24'h00_0000} : {r.adcHeld, 8'h00};
						n.sdout = eightBit ? txByte[7] : r.adcHeld[23];
						n.bitCnt = 6'h00;
						n.ser = apcl_pkg::SER_SHIFT;
					end else begin
						n.align = r.align - 2'h1;
					end
				end
			end
			apcl_pkg::SER_SHIFT: begin
				if (frameRise) begin
					// Early frame resynchronises rather than corrupting the next word
					n.ser = apcl_pkg::SER_ALIGN;
					n.align = modeB ? 2'h1 : 2'h2;
				end else if (bitRise) begin
					n.rxShift = rxNew;
					n.bitCnt = r.bitCnt + 6'h01;
					if (r.bitCnt + 6'h01 == wordLen) begin
						rxDone = 1'b1;
						n.ser = apcl_pkg::SER_IDLE;
					end
				end else if (bitFall) begin
					n.txShift = {r.txShift[30:0], 1'b0};
					n.sdout = r.txShift[30];
				end
			end
			default: begin
				n.ser = apcl_pkg::SER_IDLE;
			end
		endcase

		// DAC path: serial data or looped-back ADC data, sidetone on top
		n.dacValid = 1'b0;
		if (loopback) begin
			if (adcValid) begin
				n.dac = r.port[apcl_pkg::PORT_SIDETONE]
					? satAdd(adcSample, sidetoneSample) : adcSample;
				n.dacValid = 1'b1;
			end
		end else if (rxDone) begin
			n.dac = r.port[apcl_pkg::PORT_SIDETONE]
				? satAdd(rxLinear, sidetoneSample) : rxLinear;
			n.dacValid = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.ctrl0 <= apcl_pkg::CTRL0_RESET;
			r.ctrl1 <= apcl_pkg::CTRL1_RESET;
			r.bcdiv <= apcl_pkg::BCDIV_RESET;
			r.rate <= apcl_pkg::RATE_RESET;
			r.port <= apcl_pkg::PORT_RESET;
			r.ser <= apcl_pkg::SER_IDLE;
			r.bitOe_n <= 1'b1;
			r.frameOe_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign bitClockOut = bitGenLvl;
	assign bitClockOe_n = r.bitOe_n;
	assign frameClockOut = frameGenLvl;
	assign frameClockOe_n = r.frameOe_n;
	assign serialTransmitData = r.sdout;
	assign dacSample = r.dac;
	assign dacValid = r.dacValid;
endmodule // apcl_top
`default_nettype wire

// ### apcl_monitor.sv
// Port-level assertions for the audio port block.
// Assumes it is bound to every apcl_top instance and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module apcl_monitor (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic bitClockOut,
	input wire logic bitClockOe_n,
	input wire logic frameClockOut,
	input wire logic frameClockOe_n,
	input wire logic dacValid
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready held past access");
	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	upper_half_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("prdata upper half not zero");
	read_data_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("prdata moved outside setup");
	bit_quiet_slave_a: assert property (bitClockOe_n [*3] |-> !bitClockOut)
		else $error("bit clock output active while input");
	frame_quiet_slave_a: assert property (frameClockOe_n [*3] |-> !frameClockOut)
		else $error("frame clock output active while input");
	release_state_a: assert property ($rose(reset_n) |-> bitClockOe_n && frameClockOe_n
		&& !pready && !dacValid)
		else $error("outputs not at reset state after release");
endmodule // apcl_monitor
bind apcl_top apcl_monitor apcl_monitor_i (.clock(clock), .reset_n(reset_n), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.bitClockOut(bitClockOut), .bitClockOe_n(bitClockOe_n), .frameClockOut(frameClockOut),
	.frameClockOe_n(frameClockOe_n), .dacValid(dacValid));
`default_nettype wire

// ### apcl_host_model.sv
// Host audio interface model: slave clocks and serial receive data.
// Assumes the bench resolves its clocks against the block's clock outputs.
`timescale 1ns/1ns
`default_nettype none
module apcl_host_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic drive,
	input wire logic bitClock,
	input wire logic frameClock,
	input wire logic [7:0] word,
	input wire logic modeA,
	output logic hostBitClock,
	output logic hostFrameClock,
	output logic hostData
);
	logic [2:0] div;
	logic [2:0] slot;
	logic [3:0] left;
	logic [7:0] sh;
	logic pb, pf;
	assign hostBitClock = div[2];
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			div <= 3'h0;
			slot <= 3'h0;
			left <= 4'h0;
			sh <= 8'h00;
			pb <= 1'b0;
			pf <= 1'b0;
			hostData <= 1'b0;
			hostFrameClock <= 1'b0;
		end else begin
			pb <= bitClock;
			pf <= frameClock;
			// Clocks stand still unless the host is the source
			div <= drive ? div + 3'h1 : 3'h0;
			if (drive && div == 3'h7)
				slot <= slot + 3'h1;
			if (!drive)
				hostFrameClock <= 1'b0;
			else if (div == 3'h5)
				hostFrameClock <= (slot == 3'h7);
			if (frameClock && !pf) begin
				sh <= word;
				left <= modeA ? 4'h9 : 4'h8;
			end else if (pb && !bitClock) begin
				if (left == 4'h9)
					left <= 4'h8;
				else if (left != 4'h0) begin
					hostData <= sh[7];
					sh <= {sh[6:0], 1'b0};
					left <= left - 4'h1;
				end else
					hostData <= ~hostData;
			end
		end
	end
endmodule // apcl_host_model
`default_nettype wire

// ### tb_audio_port_clocking_compand_loopback.sv
// Self-checking bench for the audio port clocking, companding and loopback block.
// Assumes the host model and the monitor are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb_audio_port_clocking_compand_loopback;
	logic clock, reset_n, psel, penable, pwrite, pready, pslverr, useMclk, drive, adcValid;
	logic bitClockOut, bitClockOe_n, frameClockOut, frameClockOe_n, dacValid, txd, modeA;
	logic hostBitClock, hostFrameClock, hostData, bck, frm;
	logic [7:0] paddr, word, b;
	logic [31:0] pwdata, prdata, q, r;
	logic [23:0] adcSample, sidetoneSample, dacSample, s, xa, xs;
	logic [7:0] ad [5];
	logic [15:0] rs [5] = '{16'h0050, 16'h0002, 16'h0008, 16'h0022, 16'h0010};
	logic [15:0] mk [5] = '{16'h19ff, 16'h3edf, 16'h001f, 16'h07ff, 16'h00f7};
	logic [15:0] cv [4] = '{16'h000a, 16'h000a, 16'h000c, 16'h0005};
	logic [7:0] te [3] = '{8'hff, 8'h80, 8'hd5};
	logic [7:0] rb [2] = '{8'h80, 8'hff};
	logic [23:0] re [2] = '{24'h7d_7c00, 24'h00_0000};
	int rt [4] = '{7, 8, 9, 2047};
	int mismatches, comparisons, i, j, p, h;
	assign bck = bitClockOe_n ? hostBitClock : bitClockOut;
	assign frm = frameClockOe_n ? hostFrameClock : frameClockOut;
	apcl_top apcl_top_i (.clock(clock), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .masterClockIn(useMclk ? hostBitClock : 1'b0),
		.bitClockIn(useMclk ? 1'b0 : bck), .bitClockOut(bitClockOut),
		.bitClockOe_n(bitClockOe_n), .frameClockIn(frm), .frameClockOut(frameClockOut),
		.frameClockOe_n(frameClockOe_n), .serialReceiveData(hostData),
		.serialTransmitData(txd), .adcSample(adcSample), .adcValid(adcValid),
		.sidetoneSample(sidetoneSample), .dacSample(dacSample), .dacValid(dacValid));
	apcl_host_model apcl_host_model_i (.clock(clock), .reset_n(reset_n), .drive(drive),
		.bitClock(bck), .frameClock(frm), .word(word), .hostBitClock(hostBitClock),
		.hostFrameClock(hostFrameClock), .hostData(hostData), .modeA(modeA));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	function automatic int ratio(int c);
		case (c)
			0, 2: return 2;
			3: return 3;
			4: return 4;
			5: return 5;
			7: return 6;
			9: return 10;
			11: return 12;
			12: return 16;
			13: return 20;
			14: return 22;
			15: return 24;
			17: return 30;
			18: return 32;
			19: return 44;
			20: return 48;
			default: return 8;
		endcase
	endfunction
	task automatic summarize;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic fail(input string m);
		mismatches++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic hang(input int n, input int lim);
		if (n >= lim) begin
			fail("wait ran out");
			summarize();
		end
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x)
			fail($sformatf("got %h expected %h", g, x));
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic e);
		int n;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle keeps psel from being driven twice in one step
		@(posedge clock);
		hang(n, 50);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic e;
		apb(a, 1'b1, d, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic e;
		apb(a, 1'b0, 32'h0000_0000, e);
		chk(q, x);
		chk(32'(e), 32'(xe));
	endtask
	task automatic meas(input logic f, output int per, output int hi);
		int n;
		logic v, pv, st;
		st = 1'b0;
		pv = 1'b1;
		per = 0;
		hi = 0;
		for (n = 0; n < 10000; n++) begin
			@(posedge clock);
			v = f ? frameClockOut : bitClockOut;
			if (v === 1'b1 && pv === 1'b0) begin
				if (st)
					break;
				st = 1'b1;
			end
			if (st) begin
				per++;
				hi += (v === 1'b1);
			end
			pv = v;
		end
		hang(n, 10000);
	endtask
	task automatic seen(output int cb, output int cf);
		cb = 0;
		cf = 0;
		repeat (100) begin
			@(posedge clock);
			cb += (bitClockOut !== 1'b0);
			cf += (frameClockOut !== 1'b0);
		end
	endtask
	task automatic txByte(output logic [7:0] o);
		int n, k;
		logic pf, pb;
		k = 0;
		pf = 1'b1;
		pb = 1'b1;
		o = 8'h00;
		// Mode A spends one extra bit clock before the MSB
		for (n = 0; n < 2000 && k < 9 + modeA; n++) begin
			@(posedge clock);
			if (k == 0 && frameClockOut === 1'b1 && pf === 1'b0)
				k = 1;
			else if (k > 0 && bitClockOut === 1'b1 && pb === 1'b0) begin
				o = {o[6:0], txd};
				k++;
			end
			pf = frameClockOut;
			pb = bitClockOut;
		end
		hang(n, 2000);
	endtask
	task automatic dacGet(output logic [23:0] o);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (dacValid !== 1'b1 && n < 3000);
		o = dacSample;
		hang(n, 3000);
	endtask
	initial begin
		ad = '{apcl_pkg::ADDR_CTRL0, apcl_pkg::ADDR_CTRL1, apcl_pkg::ADDR_BCDIV,
			apcl_pkg::ADDR_RATE, apcl_pkg::ADDR_PORT};
		{reset_n, psel, penable, pwrite, useMclk, drive, adcValid, modeA} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		word = 8'h00;
		adcSample = 24'h00_0000;
		sidetoneSample = 24'h00_0000;
		r = $urandom(32'h170f0eba);
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		for (i = 0; i < 5; i++)
			rd(ad[i], 32'(rs[i]), 1'b0);
		chk({bitClockOe_n, frameClockOe_n}, 32'h0000_0003);
		for (i = 0; i < 5; i++) begin
			// Mode and enable bits cleared so read-only status stays zero
			r = $urandom() & {16'hffff, i == 0 ? 16'hfff0 : (i == 4 ? 16'hfffc : 16'hffff)};
			wr(ad[i], r);
			rd(ad[i], r & 32'(mk[i]), 1'b0);
		end
		wr(8'h74, 32'hffff_ffff);
		rd(8'h74, 32'h0000_0000, 1'b1);
		wr(ad[1], 32'h0000_0240);
		wr(ad[4], 32'h0000_0010);
		seen(p, h);
		chk(p + h, 0);
		chk({bitClockOe_n, frameClockOe_n}, 32'h0000_0000);
		wr(ad[4], 32'h0000_0011);
		for (i = 0; i < 32; i++) begin
			wr(ad[2], i);
			meas(1'b0, p, h);
			meas(1'b0, p, h);
			chk(p, ratio(i));
		end
		wr(ad[2], 32'h0000_0002);
		for (i = 0; i < 5; i++) begin
			j = i < 4 ? rt[i] : 8 + $urandom_range(300);
			wr(ad[3], j);
			meas(1'b1, p, h);
			meas(1'b1, p, h);
			j = j < 8 ? 8 : j;
			chk(p, j * 2);
			chk(h, j / 2 * 2);
		end
		wr(ad[1], 32'h0000_0040);
		wr(ad[3], $urandom_range(2047));
		seen(p, h);
		chk(h, 0);
		chk({bitClockOe_n, frameClockOe_n}, 32'h0000_0001);
		drive <= 1'b1;
		wr(ad[2], $urandom());
		wr(ad[1], 32'h0000_0200);
		for (i = 0; i < 2; i++) begin
			useMclk <= i[0];
			wr(ad[4], i ? 32'h0000_0001 : 32'h0000_0011);
			wr(ad[3], 8 + i * 5);
			meas(1'b1, p, h);
			meas(1'b1, p, h);
			chk(p, (8 + i * 5) * 8);
		end
		drive <= 1'b0;
		useMclk <= 1'b0;
		wr(ad[2], 32'h0000_0008);
		wr(ad[4], 32'h0000_0013);
		for (i = 0; i < 4; i++) begin
			r = $urandom();
			modeA <= i == 3;
			wr(ad[1], i == 3 ? 32'h0000_0240 : 32'h0000_0250);
			wr(ad[3], i == 3 ? 16 : 8);
			wr(ad[0], 32'(cv[i]));
			word <= i < 2 ? rb[i] : r[7:0];
			adcSample <= i == 1 ? 24'h7f_ffff : (i == 3 ? r[31:8] : 24'h00_0000);
			adcValid <= 1'b1;
			@(posedge clock);
			adcValid <= 1'b0;
			txByte(b);
			txByte(b);
			chk(32'(b), 32'(i == 3 ? r[31:24] : te[i]));
			dacGet(s);
			dacGet(s);
			chk(32'(s), i < 2 ? 32'(re[i]) : {8'h00, r[7:0], 16'h0000});
		end
		drive <= 1'b1;
		modeA <= 1'b0;
		wr(ad[1], 32'h0000_0010);
		wr(ad[0], 32'h0000_0001);
		r = $urandom();
		word <= r[7:0];
		dacGet(s);
		dacGet(s);
		chk(32'(s), {8'h00, r[7:0], 16'h0000});
		wr(ad[0], 32'h0000_0101);
		for (i = 0; i < 3; i++) begin
			r = $urandom();
			xa = i == 2 ? 24'h7f_ffff : r[23:0] & 24'h3f_ffff;
			xs = i == 2 ? 24'h00_0001 : {2'b00, r[31:10]};
			wr(ad[4], i ? 32'h0000_0017 : 32'h0000_0013);
			adcSample <= xa;
			sidetoneSample <= xs;
			adcValid <= 1'b1;
			@(posedge clock);
			adcValid <= 1'b0;
			@(posedge clock);
			chk(32'(dacValid), 32'h0000_0001);
			chk(32'(dacSample), 32'(i == 0 ? xa : (i == 1 ? xa + xs : 24'h7f_ffff)));
		end
		p = 0;
		repeat (200) begin
			@(posedge clock);
			p += (dacValid !== 1'b0);
		end
		chk(p, 0);
		summarize();
	end
endmodule // tb_audio_port_clocking_compand_loopback
`default_nettype wire
